//--- verilog/iap_flash_regs.vh
// Register indices, field positions, reset values and timing for the flash control block
`ifndef IAP_FLASH_REGS_VH
`define IAP_FLASH_REGS_VH

// ------------------------------------------------------------
// Register indices on the plain register port
// ------------------------------------------------------------
`define IDX_MAIN_CTRL     4'h0
`define IDX_CHIP_RESET    4'h1
`define IDX_BUF_CLEAR     4'h2
`define IDX_ADDR_LOW      4'h3
`define IDX_ADDR_HIGH     4'h4
`define IDX_WORD0_LOW     4'h5
`define IDX_WORD0_HIGH    4'h6
`define IDX_WORD1_LOW     4'h7
`define IDX_WORD1_HIGH    4'h8
`define IDX_WORD2_LOW     4'h9
`define IDX_WORD2_HIGH    4'ha
`define IDX_WORD3_LOW     4'hb
`define IDX_WORD3_HIGH    4'hc

// ------------------------------------------------------------
// Main control and buffer clear register fields
// ------------------------------------------------------------
`define BIT_EW_ENABLED    7
`define BIT_MODE_HI       6
`define BIT_MODE_LO       4
`define BIT_UNLOCK        3
`define BIT_PROGRAM       2
`define BIT_READ_EN       1
`define BIT_READ_INIT     0
`define BIT_BUF_CLEAR     0

// ------------------------------------------------------------
// Mode codes, patterns and reset values
// ------------------------------------------------------------
`define MODE_WRITE        3'h0
`define MODE_ERASE        3'h1
`define MODE_READ         3'h3
`define MODE_UNLOCK       3'h6
`define CHIP_RESET_KEY    8'h55
`define UNLOCK_W1_LOW     8'h00
`define UNLOCK_W1_HIGH    8'h04
`define UNLOCK_W2_LOW     8'h0d
`define UNLOCK_W2_HIGH    8'h09
`define UNLOCK_W3_LOW     8'hc3
`define UNLOCK_W3_HIGH    8'h40
`define REG_RESET         8'h00
`define ADDR_RESET        13'h0000
`define ADDR_HIGH_MASK    8'h1f
`define PAGE_LAST         5'h1f
`define ADDR_ONE          13'h0001
`define BYTE_ZERO         8'h00
`define BIT_ZERO          1'b0
`define BIT_ONE           1'b1
`define BUF_DEPTH         32
`define BUF_IDX_W         5
`define IDX_ZERO          5'h00
`define IDX_ONE           5'h01
`define WORD_ZERO         16'h0000

// ------------------------------------------------------------
// Timing defaults (cycles of mclk at 40 MHz)
// ------------------------------------------------------------
`define UNLOCK_CYCLES_DEF 1024
`define CNT_W             16
`define CNT_ZERO          16'h0000
`define CNT_ONE           16'h0001
`endif

//--- verilog/iap_flash_control.v
// Register file and sequencing for in-application programming of the program flash
// Functional notes
// - Setting unlock trigger starts procedure timer; hardware clears trigger at expiry.
// - Program initiate starts write or erase; hardware clears it on completion.
// - Reads only run while read enable is set; otherwise inhibited.
// - Read initiate starts one read; hardware clears it on completion.
// - One write setting program, read enable and read initiate together is rejected.
// - CPU is stalled while a launched read, write or erase runs.
// - Writing 55h to chip reset pattern register resets the whole chip.
// - Buffer clear bit starts buffer clearing; hardware clears it when done.
// - Unimplemented upper bits of buffer clear and address high read zero.
// - Word address is 13 bits: eight in low, five in high register.
// - Word zero low byte write only stores the byte, no buffer load.
// - Word zero high byte write loads buffer at address while erase/write enabled is set, then increments address.
// - Words one to three exist as readable, writable low and high bytes.
// - Only pattern 00,04,0D,09,C3,40 in words one to three unlocks.
// - Auto increment stops at last word of a 32-word page.
// - Mode 000 write, 001 page erase, 011 read, 110 unlock; others reserved.
// - Erase/write enabled set only by hardware; software may clear it only.
`timescale 1ns/1ps
`include "iap_flash_regs.vh"

module iap_flash_control #(
    parameter UNLOCK_CYCLES = `UNLOCK_CYCLES_DEF
) (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        clkEn,
    input  wire [3:0]  regAddr,
    input  wire [7:0]  regWdata,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [7:0]  regRdata,
    output wire        cpuStall,
    output reg         chipReset,
    output reg         flashStart,
    output reg  [2:0]  flashMode,
    output reg  [12:0] flashAddr,
    output wire [15:0] bufWord,
    output wire [4:0]  bufIndex,
    input  wire        flashDone,
    input  wire [15:0] flashRdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam ST_IDLE  = 2'h0;
    localparam ST_BUSY  = 2'h1;
    localparam ST_CLEAR = 2'h2;

    reg [1:0]  state;
    reg        ewEnabled;
    reg [2:0]  modeSel;
    reg        unlockTrig;
    reg        programInit;
    reg        readEnable;
    reg        readInit;
    reg        bufferClear;
    reg [7:0]  chipResetPattern;
    reg [12:0] flashWordAddress;
    reg [7:0]  wordLow  [0:3];
    reg [7:0]  wordHigh [0:3];
    reg [15:0] writeBuffer [0:`BUF_DEPTH-1];
    reg [`BUF_DEPTH-1:0] bufValid;
    reg [`CNT_W-1:0] unlockCount;
    reg [`BUF_IDX_W-1:0] clearIdx;

    wire wrMain  = regWrite && (regAddr == `IDX_MAIN_CTRL);
    wire wrHigh0 = regWrite && (regAddr == `IDX_WORD0_HIGH);
    wire wrClear = regWrite && (regAddr == `IDX_BUF_CLEAR);
    wire [2:0] wrMode = regWdata[`BIT_MODE_HI:`BIT_MODE_LO];

    // Three launch bits together in one write is refused outright
    wire tripleSet = regWdata[`BIT_PROGRAM] && regWdata[`BIT_READ_EN]
                     && regWdata[`BIT_READ_INIT];
    wire mainOk    = wrMain && !tripleSet;

    // Pattern compared live; must be present when the timer is still running
    wire patternOk = (wordLow[1] == `UNLOCK_W1_LOW) && (wordHigh[1] == `UNLOCK_W1_HIGH)
                  && (wordLow[2] == `UNLOCK_W2_LOW) && (wordHigh[2] == `UNLOCK_W2_HIGH)
                  && (wordLow[3] == `UNLOCK_W3_LOW) && (wordHigh[3] == `UNLOCK_W3_HIGH);

    wire timerExpire = unlockTrig
                       && (unlockCount == UNLOCK_CYCLES[`CNT_W-1:0] - `CNT_ONE);

    // Write and erase need the unlock; reads need read enable
    // Launches follow the mode in this very write, never a stale one
    wire launchProg = mainOk && regWdata[`BIT_PROGRAM] && ewEnabled
                      && ((wrMode == `MODE_WRITE) || (wrMode == `MODE_ERASE));
    wire launchRead = mainOk && regWdata[`BIT_READ_INIT] && regWdata[`BIT_READ_EN]
                      && (wrMode == `MODE_READ);

    // ------------------------------------------------------------
    // Stall and buffer view
    // ------------------------------------------------------------
    // The CPU halts for the whole operation, so software cannot poll mid-flight
    assign cpuStall = (state == ST_BUSY);
    assign bufIndex = flashWordAddress[`BUF_IDX_W-1:0];
    // Entries not loaded since the last clear show zero
    assign bufWord  = bufValid[bufIndex] ? writeBuffer[bufIndex] : `WORD_ZERO;

    // ------------------------------------------------------------
    // Control register and sequencer
    // ------------------------------------------------------------
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state       <= ST_IDLE;
            ewEnabled   <= `BIT_ZERO;
            modeSel     <= `MODE_WRITE;
            unlockTrig  <= `BIT_ZERO;
            programInit <= `BIT_ZERO;
            readEnable  <= `BIT_ZERO;
            readInit    <= `BIT_ZERO;
            bufferClear <= `BIT_ZERO;
            unlockCount <= `CNT_ZERO;
            clearIdx    <= `PAGE_LAST;
            flashStart  <= `BIT_ZERO;
            flashMode   <= `MODE_WRITE;
            flashAddr   <= `ADDR_RESET;
        end
        else if (clkEn)
        begin
            flashStart <= `BIT_ZERO;
            if (mainOk)
            begin
                modeSel    <= wrMode;
                readEnable <= regWdata[`BIT_READ_EN];
                if (!regWdata[`BIT_EW_ENABLED])
                    ewEnabled <= `BIT_ZERO;
                if (regWdata[`BIT_UNLOCK] && !unlockTrig
                    && (wrMode == `MODE_UNLOCK))
                begin
                    unlockTrig  <= `BIT_ONE;
                    unlockCount <= `CNT_ZERO;
                end
            end
            // Procedure timer
            if (unlockTrig)
            begin
                unlockCount <= unlockCount + `CNT_ONE;
                if (patternOk && (modeSel == `MODE_UNLOCK))
                    ewEnabled <= `BIT_ONE;
                if (timerExpire)
                    unlockTrig <= `BIT_ZERO;
            end
            case (state)
                ST_IDLE:
                begin
                    if (launchProg && (state == ST_IDLE))
                    begin
                        programInit <= `BIT_ONE;
                        flashStart  <= `BIT_ONE;
                        flashMode   <= wrMode;
                        flashAddr   <= flashWordAddress;
                        state       <= ST_BUSY;
                    end
                    else if (launchRead)
                    begin
                        readInit   <= `BIT_ONE;
                        flashStart <= `BIT_ONE;
                        flashMode  <= wrMode;
                        flashAddr  <= flashWordAddress;
                        state      <= ST_BUSY;
                    end
                    else if (wrClear && regWdata[`BIT_BUF_CLEAR])
                    begin
                        bufferClear <= `BIT_ONE;
                        clearIdx    <= `PAGE_LAST;
                        state       <= ST_CLEAR;
                    end
                end
                ST_BUSY:
                begin
                    if (flashDone)
                    begin
                        programInit <= `BIT_ZERO;
                        readInit    <= `BIT_ZERO;
                        state       <= ST_IDLE;
                    end
                end
                ST_CLEAR:
                begin
                    // One entry per cycle is plenty: clearing is not time critical
                    clearIdx <= clearIdx - `IDX_ONE;
                    if (clearIdx == `IDX_ZERO)
                    begin
                        bufferClear <= `BIT_ZERO;
                        state       <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address, chip reset pattern and chip reset pulse
    // ------------------------------------------------------------
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            flashWordAddress <= `ADDR_RESET;
            chipResetPattern <= `REG_RESET;
            chipReset        <= `BIT_ZERO;
        end
        else if (clkEn)
        begin
            chipReset <= regWrite && (regAddr == `IDX_CHIP_RESET)
                         && (regWdata == `CHIP_RESET_KEY);
            if (regWrite && (regAddr == `IDX_CHIP_RESET))
                chipResetPattern <= regWdata;
            if (regWrite && (regAddr == `IDX_ADDR_LOW))
                flashWordAddress[7:0] <= regWdata;
            if (regWrite && (regAddr == `IDX_ADDR_HIGH))
                flashWordAddress[12:8] <= regWdata[4:0];
            // Saturate at the page end so a runaway loop never spills pages
            if (wrHigh0 && (flashWordAddress[`BUF_IDX_W-1:0] != `PAGE_LAST))
                flashWordAddress <= flashWordAddress + `ADDR_ONE;
        end
    end

    // ------------------------------------------------------------
    // Data word byte registers and write buffer, one entry per loop step
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `BUF_DEPTH; gi = gi + 1)
        begin : gBuf
            always @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    writeBuffer[gi] <= 16'h0000;
                    bufValid[gi]    <= `BIT_ZERO;
                end
                else if (clkEn)
                begin
                    if (((state == ST_CLEAR) && (clearIdx == gi))
                        || ((state == ST_BUSY) && flashDone && (flashMode == `MODE_WRITE)))
                    begin
                        writeBuffer[gi] <= 16'h0000;
                        bufValid[gi]    <= `BIT_ZERO;
                    end
                    else if (wrHigh0 && ewEnabled
                             && (flashWordAddress[`BUF_IDX_W-1:0] == gi))
                    begin
                        writeBuffer[gi] <= {regWdata, wordLow[0]};
                        bufValid[gi]    <= `BIT_ONE;
                    end
                end
            end
        end
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : gWord
            always @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    if (gi != 0)
                    begin
                        wordLow[gi]  <= `REG_RESET;
                        wordHigh[gi] <= `REG_RESET;
                    end
                end
                else if (clkEn && (gi != 0))
                begin
                    if (regWrite && (regAddr == `IDX_WORD0_LOW + 2 * gi))
                        wordLow[gi] <= regWdata;
                    if (regWrite && (regAddr == `IDX_WORD0_HIGH + 2 * gi))
                        wordHigh[gi] <= regWdata;
                end
            end
        end
    endgenerate

    // Word zero bytes: low write only stores, high write also feeds the buffer while erase/write is enabled.
    // A finished read lands here as well, so one process owns both bytes
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wordLow[0]  <= `REG_RESET;
            wordHigh[0] <= `REG_RESET;
        end
        else if (clkEn)
        begin
            if (regWrite && (regAddr == `IDX_WORD0_LOW))
                wordLow[0] <= regWdata;
            if (wrHigh0)
                wordHigh[0] <= regWdata;
            if ((state == ST_BUSY) && flashDone && (flashMode == `MODE_READ))
            begin
                wordLow[0]  <= flashRdata[7:0];
                wordHigh[0] <= flashRdata[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the read strobe
    // ------------------------------------------------------------
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            regRdata <= `BYTE_ZERO;
        else if (clkEn)
        begin
            regRdata <= `BYTE_ZERO;
            if (regRead)
            begin
                case (regAddr)
                    `IDX_MAIN_CTRL:  regRdata <= {ewEnabled, modeSel, unlockTrig,
                                                  programInit, readEnable, readInit};
                    `IDX_CHIP_RESET: regRdata <= chipResetPattern;
                    `IDX_BUF_CLEAR:  regRdata <= {7'h00, bufferClear};
                    `IDX_ADDR_LOW:   regRdata <= flashWordAddress[7:0];
                    `IDX_ADDR_HIGH:  regRdata <= {3'h0, flashWordAddress[12:8]};
                    `IDX_WORD0_LOW:  regRdata <= wordLow[0];
                    `IDX_WORD0_HIGH: regRdata <= wordHigh[0];
                    `IDX_WORD1_LOW:  regRdata <= wordLow[1];
                    `IDX_WORD1_HIGH: regRdata <= wordHigh[1];
                    `IDX_WORD2_LOW:  regRdata <= wordLow[2];
                    `IDX_WORD2_HIGH: regRdata <= wordHigh[2];
                    `IDX_WORD3_LOW:  regRdata <= wordLow[3];
                    `IDX_WORD3_HIGH: regRdata <= wordHigh[3];
                    default:         regRdata <= `BYTE_ZERO;
                endcase
            end
        end
    end

endmodule // iap_flash_control

//--- tb/iap_flash_control_chk.sv
// Concurrent checks on the ports of the flash control block
`timescale 1ns/1ps
module iap_flash_control_chk #(
    parameter UNLOCK_CYCLES = 16
) (
    input wire        mclk,
    input wire        resetn,
    input wire        clkEn,
    input wire [3:0]  regAddr,
    input wire [7:0]  regWdata,
    input wire        regWrite,
    input wire        regRead,
    input wire [7:0]  regRdata,
    input wire        cpuStall,
    input wire        chipReset,
    input wire        flashStart,
    input wire [2:0]  flashMode,
    input wire [12:0] flashAddr,
    input wire [15:0] bufWord,
    input wire [4:0]  bufIndex,
    input wire        flashDone,
    input wire [15:0] flashRdata
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Chip reset, stall and launch relations
    // ------------------------------------------------------------
    a_reset_key_fires: assert property (clkEn && regWrite && regAddr == 4'h1 && regWdata == 8'h55 |=> chipReset)
        else $error("chip reset missing after key write");
    a_reset_needs_key: assert property (chipReset |-> $past(regWrite && regAddr == 4'h1 && regWdata == 8'h55))
        else $error("chip reset without key write");
    a_start_stalls_cpu: assert property (flashStart |-> cpuStall)
        else $error("launch without stall");
    a_stall_holds: assert property (cpuStall && !flashDone |=> cpuStall)
        else $error("stall dropped before completion");
    a_done_releases: assert property (cpuStall && flashDone && clkEn |=> !cpuStall && !flashStart)
        else $error("stall kept after completion");
    a_triple_refused: assert property (clkEn && regWrite && regAddr == 4'h0 && regWdata[2:0] == 3'h7 |=> !flashStart)
        else $error("launch from forbidden bit combination");
    a_read_needs_en: assert property (flashStart && flashMode == 3'h3 |-> $past(regWrite && regWdata[1]))
        else $error("read launched without read enable");
    a_mode_legal: assert property (flashStart |-> flashMode == 3'h0 || flashMode == 3'h1 || flashMode == 3'h3)
        else $error("launch with reserved mode");

    // ------------------------------------------------------------
    // Read-back of unimplemented bits and page boundary
    // ------------------------------------------------------------
    a_clear_upper_zero: assert property ($past(clkEn && regRead && regAddr == 4'h2) |-> regRdata[7:1] == 7'h00)
        else $error("buffer clear upper bits not zero");
    a_addr_upper_zero: assert property ($past(clkEn && regRead && regAddr == 4'h4) |-> regRdata[7:5] == 3'h0)
        else $error("address high upper bits not zero");
    a_page_end_holds: assert property (clkEn && regWrite && regAddr == 4'h6 && bufIndex == 5'h1f |=> bufIndex == 5'h1f)
        else $error("address left the page end");
endmodule // iap_flash_control_chk

bind iap_flash_control iap_flash_control_chk #(.UNLOCK_CYCLES(UNLOCK_CYCLES)) chk (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .cpuStall(cpuStall),
    .chipReset(chipReset), .flashStart(flashStart), .flashMode(flashMode),
    .flashAddr(flashAddr), .bufWord(bufWord), .bufIndex(bufIndex), .flashDone(flashDone),
    .flashRdata(flashRdata));

//--- tb/flash_array_model.sv
// Behavioural model of the flash array answering launched operations
`timescale 1ns/1ps
module flash_array_model #(
    parameter SLOW = 20
) (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        flashStart,
    input  wire [12:0] flashAddr,
    output reg         flashDone,
    output reg  [15:0] flashRdata
);
    integer left;
    reg     fast;

    // Alternate slow and prompt answers; read data toggles outside the done pulse
    // so a design sampling it at the wrong moment sees garbage
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            left       <= 0;
            fast       <= 1'b0;
            flashDone  <= 1'b0;
            flashRdata <= 16'h0000;
        end
        else
        begin
            flashDone  <= 1'b0;
            flashRdata <= ~flashRdata;
            if (flashStart)
            begin
                left <= fast ? 1 : SLOW;
                fast <= ~fast;
            end
            else if (left == 1)
            begin
                flashDone  <= 1'b1;
                flashRdata <= {3'b000, flashAddr} ^ 16'hc3a5;
                left       <= 0;
            end
            else if (left > 1)
                left <= left - 1;
        end
    end
endmodule // flash_array_model

//--- tb/iap_flash_control_regs_tb.sv
// Self-checking testbench for the flash control register block
`timescale 1ns/1ps
`include "iap_flash_regs.vh"
module iap_flash_control_regs_tb;
    localparam UNLOCK = 32;
    reg         mclk = 1'b0;
    reg         resetn = 1'b0;
    reg         clkEn = 1'b1;
    reg  [3:0]  regAddr = 4'h0;
    reg  [7:0]  regWdata = 8'h00;
    reg         regWrite = 1'b0;
    reg         regRead = 1'b0;
    wire [7:0]  regRdata;
    wire        cpuStall;
    wire        chipReset;
    wire        flashStart;
    wire [2:0]  flashMode;
    wire [12:0] flashAddr;
    wire [15:0] bufWord;
    wire [4:0]  bufIndex;
    wire        flashDone;
    wire [15:0] flashRdata;
    integer     miscompares = 0;
    integer     compares = 0;
    integer     cycles = 0;
    integer     starts = 0;
    integer     resets = 0;
    integer     tests = 0;
    integer     i;
    reg  [2:0]  lastMode = 3'h0;
    reg  [12:0] lastAddr = 13'h0000;
    logic [7:0] pat [0:5] = '{`UNLOCK_W1_LOW, `UNLOCK_W1_HIGH, `UNLOCK_W2_LOW,
                              `UNLOCK_W2_HIGH, `UNLOCK_W3_LOW, `UNLOCK_W3_HIGH};

    always #12.5 mclk = ~mclk;

    iap_flash_control #(.UNLOCK_CYCLES(UNLOCK)) uut (
        .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .cpuStall(cpuStall), .chipReset(chipReset), .flashStart(flashStart),
        .flashMode(flashMode), .flashAddr(flashAddr), .bufWord(bufWord),
        .bufIndex(bufIndex), .flashDone(flashDone), .flashRdata(flashRdata));

    flash_array_model #(.SLOW(20)) flash (
        .mclk(mclk), .resetn(resetn), .flashStart(flashStart), .flashAddr(flashAddr),
        .flashDone(flashDone), .flashRdata(flashRdata));

    // ------------------------------------------------------------
    // Comparison, bus cycles and closing report
    // ------------------------------------------------------------
    task automatic check(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Trailing idle edge keeps two strobes from being assigned in one time step
    task automatic wr(input [3:0] a, input [7:0] d);
        begin
            regAddr  <= a;
            regWdata <= d;
            regWrite <= 1'b1;
            @(posedge mclk);
            regWrite <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task automatic rd(input [3:0] a, input [7:0] e);
        begin
            regAddr <= a;
            regRead <= 1'b1;
            @(posedge mclk);
            regRead <= 1'b0;
            #1;
            check({8'h00, regRdata}, {8'h00, e});
            @(posedge mclk);
        end
    endtask

    task automatic wait_idle;
        integer n;
        begin
            n = 0;
            #1;
            while (cpuStall !== 1'b0 && n < 100)
            begin
                @(posedge mclk);
                #1;
                n = n + 1;
            end
            check({15'h0000, cpuStall}, 16'h0000);
            @(posedge mclk);
        end
    endtask

    task automatic unlock(input [7:0] spoil, input integer pause);
        begin
            wr(`IDX_MAIN_CTRL, 8'h68);
            repeat (pause) @(posedge mclk);
            for (i = 0; i < 6; i = i + 1)
                wr(`IDX_WORD1_LOW + i, pat[i] ^ (i == 0 ? spoil : 8'h00));
        end
    endtask

    task automatic note;
        begin
            tests = tests + 1;
            $display("test %0d done", tests);
        end
    endtask

    task automatic give_verdict;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // Launch and chip reset monitor, plus the hang limit
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (flashStart === 1'b1)
        begin
            starts   <= starts + 1;
            lastMode <= flashMode;
            lastAddr <= flashAddr;
        end
        if (chipReset === 1'b1)
            resets <= resets + 1;
        if (cycles == 5000)
        begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 13; i = i + 1)
            rd(i[3:0], 8'h00);
        wr(`IDX_MAIN_CTRL, 8'h80);
        rd(`IDX_MAIN_CTRL, 8'h00);
        note;
        // Wrong byte, then a late pattern: neither may enable
        unlock(8'h01, 0);
        repeat (UNLOCK + 8) @(posedge mclk);
        rd(`IDX_MAIN_CTRL, 8'h60);
        unlock(8'h00, UNLOCK + 8);
        rd(`IDX_MAIN_CTRL, 8'h60);
        unlock(8'h00, 0);
        rd(`IDX_MAIN_CTRL, 8'he8);
        repeat (UNLOCK + 8) @(posedge mclk);
        rd(`IDX_MAIN_CTRL, 8'he0);
        for (i = 0; i < 6; i = i + 1)
            rd(`IDX_WORD1_LOW + i, pat[i]);
        clkEn <= 1'b0;
        wr(`IDX_WORD1_LOW, 8'haa);
        clkEn <= 1'b1;
        rd(`IDX_WORD1_LOW, 8'h00);
        note;
        // Buffer clear, address pair and page-end loading
        wr(`IDX_ADDR_LOW, 8'h1e);
        wr(`IDX_ADDR_HIGH, 8'hff);
        rd(`IDX_ADDR_HIGH, 8'h1f);
        wr(`IDX_WORD0_LOW, 8'h34);
        rd(`IDX_ADDR_LOW, 8'h1e);
        check(bufWord, 16'h0000);
        wr(`IDX_WORD0_HIGH, 8'h12);
        rd(`IDX_ADDR_LOW, 8'h1f);
        wr(`IDX_WORD0_LOW, 8'h78);
        wr(`IDX_WORD0_HIGH, 8'h56);
        rd(`IDX_ADDR_LOW, 8'h1f);
        check(bufWord, 16'h5678);
        wr(`IDX_ADDR_LOW, 8'h1e);
        check(bufWord, 16'h1234);
        wr(`IDX_BUF_CLEAR, 8'hff);
        rd(`IDX_BUF_CLEAR, 8'h01);
        repeat (40) @(posedge mclk);
        rd(`IDX_BUF_CLEAR, 8'h00);
        check(bufWord, 16'h0000);
        wr(`IDX_WORD0_HIGH, 8'h12);
        wr(`IDX_ADDR_LOW, 8'h1e);
        note;
        // Erase then write, slow and prompt answers
        for (i = 0; i < 2; i = i + 1)
        begin
            wr(`IDX_MAIN_CTRL, i == 0 ? 8'h94 : 8'h84);
            wait_idle;
            rd(`IDX_MAIN_CTRL, i == 0 ? 8'h90 : 8'h80);
            check(starts, i + 1);
            check(lastMode, i == 0 ? `MODE_ERASE : `MODE_WRITE);
            check(lastAddr, 13'h1f1e);
        end
        check(bufWord, 16'h0000);
        wr(`IDX_MAIN_CTRL, 8'h87);
        rd(`IDX_MAIN_CTRL, 8'h80);
        wr(`IDX_MAIN_CTRL, 8'hb1);
        wait_idle;
        check(starts, 2);
        note;
        // Single read lands in word zero
        wr(`IDX_MAIN_CTRL, 8'hb3);
        wait_idle;
        check(lastMode, `MODE_READ);
        rd(`IDX_WORD0_LOW, 8'ha5 ^ 8'h1e);
        rd(`IDX_WORD0_HIGH, 8'hc3 ^ 8'h1f);
        rd(`IDX_MAIN_CTRL, 8'hb2);
        wr(`IDX_MAIN_CTRL, 8'h30);
        rd(`IDX_MAIN_CTRL, 8'h30);
        note;
        // Chip reset pattern register
        wr(`IDX_CHIP_RESET, 8'h54);
        rd(`IDX_CHIP_RESET, 8'h54);
        check(resets, 0);
        wr(`IDX_CHIP_RESET, 8'h55);
        #1;
        check(resets, 1);
        note;
        give_verdict;
    end
endmodule // iap_flash_control_regs_tb
